/* bench/anf_ctrl_sva.sv */
// Purpose: Port-level checks for the adaptive notch control block.
// Assumes: One clock domain; SAVE_CYCLES is at most 300 in simulation.
// Notes:   Host writes are exempt from the range checks.
`timescale 1ns/10ps
module anf_ctrl_sva #(
  parameter logic [36:0] SAVE_CYCLES = 37'h14
) (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        thrust_mode_in,
  input wire logic        servo_on_in,
  input wire logic        pole_est_busy_in,
  input wire logic        adapt_active_out,
  input wire logic [15:0] f3_out,
  input wire logic [15:0] w3_out,
  input wire logic [15:0] d3_out,
  input wire logic [15:0] f4_out,
  input wire logic        nv_save_out,
  input wire logic [15:0] nv_freq3_out,
  input wire logic [15:0] nv_freq3_in
);
  localparam int P = int'(SAVE_CYCLES);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ==========================================================================
  // Bus handshake: a waiting request is answered for exactly one cycle
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  // ==========================================================================
  // Gates drop the active flag one cycle later
  a_thrust_block: assert property (thrust_mode_in |=> !adapt_active_out)
    else $error("active in thrust mode");
  a_servo_block: assert property (!servo_on_in |=> !adapt_active_out)
    else $error("active with servo off");
  a_pole_block: assert property (pole_est_busy_in |=> !adapt_active_out)
    else $error("active during pole estimation");
  // ==========================================================================
  // Automatic changes stay inside the legal ranges
  a_f3_range: assert property ($changed(f3_out) && !$past(avs_write_in) |->
    f3_out inside {[16'h0032:16'h1388]}) else $error("f3 out of range");
  a_f4_range: assert property ($changed(f4_out) && !$past(avs_write_in) |->
    f4_out inside {[16'h0032:16'h1388]}) else $error("f4 out of range");
  a_w3d3_range: assert property ($changed({w3_out, d3_out}) &&
    !$past(avs_write_in) |-> w3_out <= 16'h0014 && d3_out <= 16'h0063)
    else $error("w3/d3 range");
  // Save pulse period and stored value
  a_save_period: assert property (nv_save_out |-> ##P nv_save_out)
    else $error("save period wrong");
  // Saved start value is taken, clamped, on the first edge after reset
  a_nv_restore: assert property ($fell(srst_in) |=> nv_freq3_out ==
    ((nv_freq3_in < 16'h0032) ? 16'h0032 :
     (nv_freq3_in > 16'h1388) ? 16'h1388 : nv_freq3_in))
    else $error("start frequency not restored");
endmodule : anf_ctrl_sva

/* bench/anf_est_model.sv */
// Purpose: Resonance estimator stand-in feeding results to the block.
// Assumes: go_in is a one-cycle request from the bench.
// Notes:   Frequency lines scramble between reports, as a real source may.
`timescale 1ns/10ps
module anf_est_model (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [15:0] f1_in,
  input  wire logic [15:0] f2_in,
  input  wire logic [15:0] wd_in,
  output logic             valid_out,
  output logic             found1_out,
  output logic [15:0]      freq1_out,
  output logic             found2_out,
  output logic [15:0]      freq2_out,
  output logic [15:0]      width_out,
  output logic [15:0]      depth_out
);
  // Zero means no resonance; only two slots, so never three peaks
  always_ff @(posedge clk_in)
  begin
    valid_out  <= go_in;
    found1_out <= (f1_in != 16'h0000);
    found2_out <= (f2_in != 16'h0000);
    freq1_out  <= go_in ? f1_in : ~freq1_out;
    freq2_out  <= go_in ? f2_in : ~freq2_out;
    width_out  <= wd_in;
    depth_out  <= wd_in << 2;
  end
endmodule : anf_est_model

/* bench/tb_anf_ctrl.sv */
// Purpose: Register-level test of the adaptive notch control block.
// Assumes: Save interval shortened to 20 cycles.
// Notes:   Bus tasks add one idle cycle between accesses.
`timescale 1ns/10ps
`include "anf_cfg.svh"
module tb_anf_ctrl;
  logic clk_in = 0, srst_in = 1, rd = 0, wr = 0, thr = 0, srv = 1, pole = 0;
  logic mot = 0, go = 0, ev, e1, e2, wt, sv;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdt = 32'h0, rdt, got;
  logic [15:0] f1 = 16'h0, f2 = 16'h0, wd = 16'h0, q1, q2, ew, ed, f3;
  logic act;
  logic [15:0] nv4, w4, d4;
  int mismatches = 0, checks = 0, saves = 0;
  anf_est_model anf_est_model_i (.clk_in(clk_in), .go_in(go), .f1_in(f1),
    .f2_in(f2), .wd_in(wd), .valid_out(ev), .found1_out(e1),
    .freq1_out(q1), .found2_out(e2), .freq2_out(q2), .width_out(ew),
    .depth_out(ed));
  anf_ctrl #(.SAVE_CYCLES(37'h14)) anf_ctrl_i (.clk_in(clk_in),
    .srst_in(srst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdt), .avs_readdata_out(rdt),
    .avs_waitrequest_out(wt), .thrust_mode_in(thr), .servo_on_in(srv),
    .pole_est_busy_in(pole), .motion_cmd_in(mot), .est_valid_in(ev),
    .est1_found_in(e1), .est1_freq_in(q1), .est1_width_in(ew),
    .est1_depth_in(ed), .est2_found_in(e2), .est2_freq_in(q2),
    .est2_width_in(ew), .est2_depth_in(ed), .nv_freq3_in(16'h000A),
    .nv_freq4_in(16'h2000), .nv_save_out(sv), .nv_freq3_out(),
    .nv_freq4_out(nv4), .adapt_active_out(act), .f3_out(f3), .w3_out(),
    .d3_out(), .f4_out(), .w4_out(w4), .d4_out(d4));
  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    #(25 * 4000);
    mismatches++;
    final_report();
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk_in);
    adr <= a;
    wdt <= {16'h0000, d};
    wr  <= w;
    rd  <= !w;
    do @(posedge clk_in); while (wt !== 1'b0);
    got = rdt;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    bus(a, 1'b0, 16'h0);
    chk(got, {16'h0000, e});
  endtask : rc
  task automatic arm(input logic [15:0] m);
    bus(`ANF_OFS_MODE, 1'b1, m);
    @(posedge clk_in) mot <= 1'b1;
    @(posedge clk_in) mot <= 1'b0;
  endtask : arm
  // Report waits briefly for the active flag, then goes anyway
  task automatic est(input logic [15:0] a, input logic [15:0] b,
                     input logic [15:0] w);
    for (int i = 0; i < 5 && act !== 1'b1; i++) @(negedge clk_in);
    @(posedge clk_in);
    f1 <= a;
    f2 <= b;
    wd <= w;
    go <= 1'b1;
    @(posedge clk_in) go <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : est
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rc(`ANF_OFS_F3, 16'h0032);
    rc(`ANF_OFS_F4, 16'h1388);
    rc(`ANF_OFS_MODE, 16'h0000);
    rc(8'h3C, 16'h0000);
    $display("test reset done");
    arm(16'h0000);
    est(16'd100, 16'd200, 16'd5);
    rc(`ANF_OFS_F3, 16'h0032);
    rc(`ANF_OFS_STATUS, 16'h0000);
    arm(16'h0001);
    est(16'd100, 16'd200, 16'd5);
    rc(`ANF_OFS_F3, 16'h0064);
    rc(`ANF_OFS_W3, 16'h0005);
    rc(`ANF_OFS_D3, 16'h0014);
    rc(`ANF_OFS_F4, 16'h1388);
    rc(`ANF_OFS_W4, 16'h0000);
    arm(16'h0002);
    est(16'd20, 16'd6000, 16'd30);
    rc(`ANF_OFS_F3, 16'h0032);
    rc(`ANF_OFS_F4, 16'h1388);
    rc(`ANF_OFS_W4, 16'h0014);
    rc(`ANF_OFS_D4, 16'h0063);
    chk({16'h0000, w4}, 32'h00000014);
    chk({16'h0000, d4}, 32'h00000063);
    est(16'd0, 16'd300, 16'd2);
    rc(`ANF_OFS_F3, 16'h1388);
    rc(`ANF_OFS_F4, 16'h012C);
    rc(`ANF_OFS_STATUS, 16'h000B);
    $display("test modes 0-2 done");
    arm(16'h0003);
    est(16'd300, 16'd400, 16'd1);
    rc(`ANF_OFS_F3, 16'h1388);
    rc(`ANF_OFS_MEAS1, 16'h012C);
    rc(`ANF_OFS_MEAS2, 16'h0190);
    arm(16'h0004);
    rc(`ANF_OFS_F4, 16'h1388);
    rc(`ANF_OFS_MEAS1, 16'h0000);
    chk({16'h0000, nv4}, 32'h00001388);
    $display("test modes 3-4 done");
    arm(16'h0001);
    // Each gate alone must block a report
    for (int g = 0; g < 3; g++)
    begin
      @(posedge clk_in);
      thr  <= (g == 0);
      srv  <= (g != 1);
      pole <= (g == 2);
      repeat (2) @(posedge clk_in);
      est(16'd700, 16'd0, 16'd1);
      rc(`ANF_OFS_F3, 16'h1388);
    end
    @(posedge clk_in);
    {thr, srv, pole} <= 3'b010;
    est(16'd700, 16'd0, 16'd1);
    rc(`ANF_OFS_F3, 16'h02BC);
    chk({16'h0000, f3}, 32'h000002BC);
    // Two save pulses in any window of two intervals
    repeat (40)
    begin
      @(posedge clk_in);
      saves += (sv === 1'b1);
    end
    chk(32'(saves), 32'h00000002);
    $display("test gates done");
    final_report();
  end
endmodule : tb_anf_ctrl
bind anf_ctrl anf_ctrl_sva #(.SAVE_CYCLES(SAVE_CYCLES)) anf_ctrl_sva_i (
  .clk_in, .srst_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .thrust_mode_in, .servo_on_in, .pole_est_busy_in, .adapt_active_out,
  .f3_out, .w3_out, .d3_out, .f4_out, .nv_save_out, .nv_freq3_out,
  .nv_freq3_in);

/* logic/anf_cfg.svh */
// Purpose: Offsets, field limits, reset values and timing for the adaptive
//          notch filter control block.
// Assumes: 32-bit Avalon-MM data, byte addresses, one register per word.
// Notes:   Definitions only.
`ifndef ANF_CFG_SVH
`define ANF_CFG_SVH

// ==========================================================================
// Register byte offsets
`define ANF_OFS_MODE    8'h00
`define ANF_OFS_F3      8'h04
`define ANF_OFS_W3      8'h08
`define ANF_OFS_D3      8'h0C
`define ANF_OFS_F4      8'h10
`define ANF_OFS_W4      8'h14
`define ANF_OFS_D4      8'h18
`define ANF_OFS_MEAS1   8'h1C
`define ANF_OFS_MEAS2   8'h20
`define ANF_OFS_STATUS  8'h24

// ==========================================================================
// Status register bit positions
`define ANF_ST_ACTIVE   0
`define ANF_ST_STARTED  1
`define ANF_ST_FOUND1   2
`define ANF_ST_FOUND2   3

// ==========================================================================
// Mode codes
`define ANF_MODE_OFF    16'h0000
`define ANF_MODE_ONE    16'h0001
`define ANF_MODE_TWO    16'h0002
`define ANF_MODE_MEAS   16'h0003
`define ANF_MODE_CLR    16'h0004

// ==========================================================================
// Field limits and reset values
`define ANF_FREQ_MIN    16'h0032
`define ANF_FREQ_DIS    16'h1388
`define ANF_WIDTH_MAX   16'h0014
`define ANF_DEPTH_MAX   16'h0063
`define ANF_RST_MODE    16'h0000
`define ANF_RST_WIDTH   16'h0000
`define ANF_RST_DEPTH   16'h0000

// ==========================================================================
// Timing
`define ANF_CLK_HZ      64'd40000000
`define ANF_SAVE_MIN    64'd30
`define ANF_SAVE_CYC    37'(`ANF_SAVE_MIN * 64'd60 * `ANF_CLK_HZ)

`endif

/* logic/anf_ctrl.sv */
// Purpose: Adaptive notch filter control: gates adaptation, writes third and
//          fourth notch settings from estimator results, Avalon-MM slave.
// Assumes: Estimator and nonvolatile store are outside; inputs synchronous.
// Notes:   Register data sit in bits 15:0, upper bits read zero.
`timescale 1ns/10ps
`include "anf_cfg.svh"

module anf_ctrl #(
  parameter logic [36:0] SAVE_CYCLES = `ANF_SAVE_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Drive conditions
  input  wire logic        thrust_mode_in,
  input  wire logic        servo_on_in,
  input  wire logic        pole_est_busy_in,
  input  wire logic        motion_cmd_in,
  // Estimator results
  input  wire logic        est_valid_in,
  input  wire logic        est1_found_in,
  input  wire logic [15:0] est1_freq_in,
  input  wire logic [15:0] est1_width_in,
  input  wire logic [15:0] est1_depth_in,
  input  wire logic        est2_found_in,
  input  wire logic [15:0] est2_freq_in,
  input  wire logic [15:0] est2_width_in,
  input  wire logic [15:0] est2_depth_in,
  // Nonvolatile store
  input  wire logic [15:0] nv_freq3_in,
  input  wire logic [15:0] nv_freq4_in,
  output logic             nv_save_out,
  output logic [15:0]      nv_freq3_out,
  output logic [15:0]      nv_freq4_out,
  // Settings to the notch filters
  output logic             adapt_active_out,
  output logic [15:0]      f3_out,
  output logic [15:0]      w3_out,
  output logic [15:0]      d3_out,
  output logic [15:0]      f4_out,
  output logic [15:0]      w4_out,
  output logic [15:0]      d4_out
);

  anf_pkg::anf_regs_t s_q;
  anf_pkg::anf_regs_t s_d;
  logic               save_tick;
  logic               req;
  logic               wr_go;
  logic               gate_ok;
  logic               mode_run;

  // ========================================================================
  // Range helpers
  function automatic logic [15:0] clamp_freq(input logic [15:0] f);
    if (f < `ANF_FREQ_MIN)
      clamp_freq = `ANF_FREQ_MIN;
    else if (f > `ANF_FREQ_DIS)
      clamp_freq = `ANF_FREQ_DIS;
    else
      clamp_freq = f;
  endfunction : clamp_freq

  function automatic logic [15:0] clamp_max(input logic [15:0] v,
                                            input logic [15:0] mx);
    clamp_max = (v > mx) ? mx : v;
  endfunction : clamp_max

  // ========================================================================
  // Thirty-minute save interval
  anf_save_timer #(
    .CYCLES   (SAVE_CYCLES)
  ) u_timer (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .tick_out (save_tick)
  );

  // ========================================================================
  // Bus request and adaptation gating
  assign req      = avs_read_in | avs_write_in;
  assign wr_go    = avs_write_in & ~s_q.wt;
  // All three drive conditions must hold together
  assign gate_ok  = ~thrust_mode_in
                  & servo_on_in
                  & ~pole_est_busy_in;
  assign mode_run = (s_q.mode == `ANF_MODE_ONE) ||
                    (s_q.mode == `ANF_MODE_TWO) ||
                    (s_q.mode == `ANF_MODE_MEAS);

  // ========================================================================
  // Register map, one 16-bit field per 32-bit word, upper half reads zero
  //   0x00 mode        0 off, 1 one filter, 2 two filters,
  //                    3 measure only, 4 clear; others hold the settings
  //   0x04 f3          third notch frequency, 5000 means disabled
  //   0x08 w3          third notch width, automatic range 0..20
  //   0x0C d3          third notch depth, automatic range 0..99
  //   0x10 f4          fourth notch frequency, 5000 means disabled
  //   0x14 w4          fourth notch width, two-filter mode only
  //   0x18 d4          fourth notch depth, two-filter mode only
  //   0x1C meas1       last first resonance, read only
  //   0x20 meas2       last second resonance, read only
  //   0x24 status      bit 0 active, 1 started, 2 found1, 3 found2
  // Host writes are stored as written; only automatic values are clamped,
  // so a host can still park a notch outside the automatic range.
  // Writes to read-only or unmapped words are dropped; reads of unmapped words return zero.
  //
  // Bus timing
  //   Edge N:   request seen with waitrequest high; read data latched
  //   Edge N+1: waitrequest low; write lands, master takes read data
  //   Edge N+2: waitrequest high again, next request may be seen
  // Read data are captured one cycle early so the answer needs no mux
  // after the register; the price is one wait state on every access.
  //
  // Adaptation timing
  //   A motion command in any nonzero mode except 4 sets started.
  //   Active follows started, the three drive conditions and a running
  //   mode one cycle later, so a gate that drops stops the next report.
  //   An estimator report is taken only on an edge where active is high.
  //   Settings change on that same edge and are visible the cycle after.
  //   An estimator report beats a host write to the same field.
  //   Mode 4 rewrites its values on every cycle, so host writes to the
  //   third and fourth frequencies do not stick while it is selected.
  //
  // Save timing
  //   The timer pulses once per interval from reset; the store takes the
  //   frequency outputs on the cycle of the pulse.

  // ========================================================================
  // Next state
  always_comb
  begin
    s_d      = s_q;
    s_d.save = 1'b0;

    // Bus handshake: one wait cycle, data latched while waitrequest is high
    s_d.wt = ~(req & s_q.wt);
    if (avs_read_in && s_q.wt)
    begin
      s_d.rdata = 32'h0;
      unique case (avs_address_in)
        `ANF_OFS_MODE:   s_d.rdata[15:0] = s_q.mode;
        `ANF_OFS_F3:     s_d.rdata[15:0] = s_q.f3;
        `ANF_OFS_W3:     s_d.rdata[15:0] = s_q.w3;
        `ANF_OFS_D3:     s_d.rdata[15:0] = s_q.d3;
        `ANF_OFS_F4:     s_d.rdata[15:0] = s_q.f4;
        `ANF_OFS_W4:     s_d.rdata[15:0] = s_q.w4;
        `ANF_OFS_D4:     s_d.rdata[15:0] = s_q.d4;
        `ANF_OFS_MEAS1:  s_d.rdata[15:0] = s_q.meas1;
        `ANF_OFS_MEAS2:  s_d.rdata[15:0] = s_q.meas2;
        `ANF_OFS_STATUS:
        begin
          s_d.rdata[`ANF_ST_ACTIVE]  = s_q.active;
          s_d.rdata[`ANF_ST_STARTED] = s_q.started;
          s_d.rdata[`ANF_ST_FOUND1]  = s_q.found1;
          s_d.rdata[`ANF_ST_FOUND2]  = s_q.found2;
        end
        default:         s_d.rdata = 32'h0;
      endcase
    end

    // Host writes; estimator updates below override in the same cycle
    if (wr_go)
    begin
      unique case (avs_address_in)
        `ANF_OFS_MODE: s_d.mode = avs_writedata_in[15:0];
        `ANF_OFS_F3:   s_d.f3   = avs_writedata_in[15:0];
        `ANF_OFS_W3:   s_d.w3   = avs_writedata_in[15:0];
        `ANF_OFS_D3:   s_d.d3   = avs_writedata_in[15:0];
        `ANF_OFS_F4:   s_d.f4   = avs_writedata_in[15:0];
        `ANF_OFS_W4:   s_d.w4   = avs_writedata_in[15:0];
        `ANF_OFS_D4:   s_d.d4   = avs_writedata_in[15:0];
        default:       s_d.mode = s_d.mode;
      endcase
    end

    unique case (s_q.st)
      // First cycle after reset: take saved frequencies as start values
      anf_pkg::ANF_ST_LOAD:
      begin
        s_d.f3 = clamp_freq(nv_freq3_in);
        s_d.f4 = clamp_freq(nv_freq4_in);
        s_d.st = anf_pkg::ANF_ST_RUN;
      end
      anf_pkg::ANF_ST_RUN:
      begin
        // A motion command arms adaptation in any nonzero mode except 4
        if (s_q.mode == `ANF_MODE_OFF)
          s_d.started = 1'b0;
        else if (motion_cmd_in)
          s_d.started = 1'b1;

        s_d.active = s_q.started & gate_ok & mode_run;

        if (s_q.mode == `ANF_MODE_CLR)
        begin
          // Notches parked at the disabled frequency, results wiped
          s_d.f3      = `ANF_FREQ_DIS;
          s_d.f4      = `ANF_FREQ_DIS;
          s_d.meas1   = 16'h0000;
          s_d.meas2   = 16'h0000;
          s_d.found1  = 1'b0;
          s_d.found2  = 1'b0;
          s_d.started = 1'b0;
          s_d.active  = 1'b0;
        end
        else if (s_q.active && est_valid_in)
        begin
          // Measured results are kept in every running mode
          s_d.found1 = est1_found_in;
          s_d.found2 = est2_found_in;
          s_d.meas1  = est1_found_in ? clamp_freq(est1_freq_in)
                                     : `ANF_FREQ_DIS;
          s_d.meas2  = est2_found_in ? clamp_freq(est2_freq_in)
                                     : `ANF_FREQ_DIS;
          // Mode 3 stops here, so notch settings hold
          if (s_q.mode == `ANF_MODE_ONE ||
              s_q.mode == `ANF_MODE_TWO)
          begin
            s_d.f3 = est1_found_in ? clamp_freq(est1_freq_in)
                                   : `ANF_FREQ_DIS;
            s_d.w3 = clamp_max(est1_width_in, `ANF_WIDTH_MAX);
            s_d.d3 = clamp_max(est1_depth_in, `ANF_DEPTH_MAX);
          end
          if (s_q.mode == `ANF_MODE_TWO)
          begin
            s_d.f4 = est2_found_in ? clamp_freq(est2_freq_in)
                                   : `ANF_FREQ_DIS;
            s_d.w4 = clamp_max(est2_width_in, `ANF_WIDTH_MAX);
            s_d.d4 = clamp_max(est2_depth_in, `ANF_DEPTH_MAX);
          end
        end

        // Periodic save; a power loss inside an interval loses that result
        s_d.save = save_tick;
      end
    endcase
  end

  // ========================================================================
  // State register; frequencies reset to the disabled value until loaded
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s_q         <= '0;
      s_q.st      <= anf_pkg::ANF_ST_LOAD;
      s_q.mode    <= `ANF_RST_MODE;
      s_q.f3      <= `ANF_FREQ_DIS;
      s_q.w3      <= `ANF_RST_WIDTH;
      s_q.d3      <= `ANF_RST_DEPTH;
      s_q.f4      <= `ANF_FREQ_DIS;
      s_q.w4      <= `ANF_RST_WIDTH;
      s_q.d4      <= `ANF_RST_DEPTH;
      s_q.wt      <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  assign avs_readdata_out    = s_q.rdata;
  assign avs_waitrequest_out = s_q.wt;
  assign nv_save_out         = s_q.save;
  assign nv_freq3_out        = s_q.f3;
  assign nv_freq4_out        = s_q.f4;
  assign adapt_active_out    = s_q.active;
  assign f3_out              = s_q.f3;
  assign w3_out              = s_q.w3;
  assign d3_out              = s_q.d3;
  assign f4_out              = s_q.f4;
  assign w4_out              = s_q.w4;
  assign d4_out              = s_q.d4;

endmodule : anf_ctrl

/* logic/anf_pkg.sv */
// Purpose: Types shared by the adaptive notch filter control files.
// Assumes: Constants live in anf_cfg.svh.
// Notes:   One-hot state codes are written out.
package anf_pkg;

  // ========================================================================
  // Control states
  typedef enum logic [1:0] {
    ANF_ST_LOAD = 2'b01,
    ANF_ST_RUN  = 2'b10
  } anf_state_t;

  // ========================================================================
  // Whole state of the control block
  typedef struct packed {
    anf_state_t  st;
    logic [15:0] mode;
    logic [15:0] f3;
    logic [15:0] w3;
    logic [15:0] d3;
    logic [15:0] f4;
    logic [15:0] w4;
    logic [15:0] d4;
    logic [15:0] meas1;
    logic [15:0] meas2;
    logic        started;
    logic        found1;
    logic        found2;
    logic        active;
    logic        wt;
    logic [31:0] rdata;
    logic        save;
  } anf_regs_t;

  // ========================================================================
  // State of the save interval timer
  typedef struct packed {
    logic [36:0] cnt;
    logic        tick;
  } anf_tmr_t;

endpackage : anf_pkg

/* logic/anf_save_timer.sv */
// Purpose: Free-running interval timer giving a one-cycle tick.
// Assumes: CYCLES is at least 2.
// Notes:   Tick comes straight from a flip-flop.
`timescale 1ns/10ps
`include "anf_cfg.svh"

module anf_save_timer #(
  parameter logic [36:0] CYCLES = `ANF_SAVE_CYC
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  output logic      tick_out
);

  anf_pkg::anf_tmr_t s_q;
  anf_pkg::anf_tmr_t s_d;

  // ========================================================================
  // Next state: wrap and tick once per interval
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == CYCLES - 37'h1)
    begin
      s_d.cnt  = 37'h0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 37'h1;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

endmodule : anf_save_timer
